// file: rtl/adcphp_port.sv
`default_nettype none
// Functional notes
// - high select shows result bits 11..8
// - low select shows result bits 7..0
// - done output low when result ready
// - read starts on read fall, select low
// - internal acquisition: write rise latches config, starts
// - external acquisition: next write rise starts conversion
// - select high keeps data lines released
// - read fall returns done output high
// - hold on fourth converter clock fall
// - tracking begins on write rise
module adcphp_port #(
  parameter logic [3:0] HOLD_COUNT = adcphp_pkg::HOLD_EDGES,
  parameter logic [3:0] CONV_COUNT = adcphp_pkg::CONV_EDGES,
  parameter logic [3:0] CLK_DIV = adcphp_pkg::INT_CLK_DIV
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic high_byte_select,
  input wire logic conv_clk_pin,
  input wire logic [7:0] data_in,
  input wire logic [adcphp_pkg::RESULT_W-1:0] sar_code,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic conv_done_n,
  output logic track_hold,
  output logic [7:0] config_byte
);
  import adcphp_pkg::*;

  typedef struct packed {
    adcphp_state_type state;
    logic [7:0] cfg;
    logic [3:0] edges;
    logic [3:0] div;
    logic [RESULT_W-1:0] result;
    logic done_n;
    logic [7:0] dout;
    logic doe;
    logic track;
  } adcphp_port_state_type;

  adcphp_port_state_type r_ff, nxt_r;
  adcphp_pins_type lvl, rise, fall;
  logic cs_low;
  logic wr_rise;
  logic rd_fall;
  logic int_tick;
  logic cedge;
  logic conv_finish;

  // every pin is asynchronous to clk, so all pass two flops
  adcphp_sync #(.W($bits(adcphp_pins_type)), .RST_VAL(PINS_IDLE)) u_sync (
    .clk(clk),
    .reset(reset),
    .din({cs_n, rd_n, wr_n, high_byte_select, conv_clk_pin, data_in}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // strobe qualification; the host keeps select ahead of the strobes
  assign cs_low = ~lvl.cs_n;
  assign wr_rise = rise.wr_n & cs_low;
  assign rd_fall = fall.rd_n & cs_low;
  // converter clock: external pin falls or internal divider
  assign int_tick = (r_ff.div == CLK_DIV - 4'h1);
  assign cedge = r_ff.cfg[CFG_CLK_BIT] ? fall.conv_clk : int_tick;
  assign conv_finish = (r_ff.state == ST_CONVERT) && cedge && (r_ff.edges == CONV_COUNT - 4'h1);

  // next-state logic of the whole port
  always_comb begin
    nxt_r = r_ff;
    nxt_r.div = int_tick ? 4'h0 : r_ff.div + 4'h1;
    // read path: enable only from a qualified read fall
    nxt_r.doe = cs_low & ~lvl.rd_n & (r_ff.doe | rd_fall);
    if (lvl.high_byte_select) begin
      nxt_r.dout = {HIGH_PAD, r_ff.result[RESULT_W-1:LOW_W]};
    end else begin
      nxt_r.dout = r_ff.result[LOW_W-1:0];
    end
    // a completion in this same cycle overrides the clear below: set wins
    if (rd_fall) begin
      nxt_r.done_n = 1'b1;
    end
    // one counter serves both the hold and the conversion phase
    if (cedge) begin
      nxt_r.edges = r_ff.edges + 4'h1;
    end
    case (r_ff.state)
      ST_IDLE, ST_CONVERT: begin
        if (r_ff.state == ST_CONVERT && conv_finish) begin
          nxt_r.result = sar_code;
          nxt_r.done_n = 1'b0;
          nxt_r.state = ST_IDLE;
        end
        // a new write aborts a conversion in flight
        if (wr_rise) begin
          nxt_r.cfg = lvl.data;
          nxt_r.track = 1'b1;
          nxt_r.edges = 4'h0;
          nxt_r.state = lvl.data[CFG_ACQ_BIT] ? ST_TRACK_EXT : ST_TRACK_INT;
        end
      end
      ST_TRACK_INT: begin
        // writes are ignored until hold; host must not strobe early
        if (cedge && r_ff.edges == HOLD_COUNT - 4'h1) begin
          nxt_r.track = 1'b0;
          nxt_r.edges = 4'h0;
          nxt_r.state = ST_CONVERT;
        end
      end
      ST_TRACK_EXT: begin
        nxt_r.edges = 4'h0;
        if (wr_rise) begin
          nxt_r.track = 1'b0;
          nxt_r.state = ST_CONVERT;
        end
      end
      default: begin
        nxt_r.state = ST_IDLE;
        nxt_r.track = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_ff <= '{state: ST_IDLE, cfg: CFG_RESET, edges: 4'h0, div: 4'h0, result: RESULT_RESET,
                done_n: 1'b1, dout: DATA_RESET, doe: 1'b0, track: 1'b0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  // outputs come straight from the state flops, never through gates
  assign data_out = r_ff.dout;
  assign data_oe = r_ff.doe;
  assign conv_done_n = r_ff.done_n;
  assign track_hold = r_ff.track;
  assign config_byte = r_ff.cfg;

  // byte mux, flag and acquisition basics
  AST_HIGH_BYTE: assert property (@(posedge clk) disable iff (reset)
    lvl.high_byte_select |=> data_out == {HIGH_PAD, $past(r_ff.result[RESULT_W-1:LOW_W])})
    else $error("high byte mux wrong");
  AST_LOW_BYTE: assert property (@(posedge clk) disable iff (reset)
    !lvl.high_byte_select |=> data_out == $past(r_ff.result[LOW_W-1:0]))
    else $error("low byte mux wrong");
  AST_DONE_SET: assert property (@(posedge clk) disable iff (reset)
    conv_finish |=> !conv_done_n && r_ff.result == $past(sar_code))
    else $error("done not asserted on completion");
  AST_READ_START: assert property (@(posedge clk) disable iff (reset)
    !data_oe ##1 data_oe |-> $past(rd_fall))
    else $error("bus driven without read fall");
  AST_CFG_LATCH: assert property (@(posedge clk) disable iff (reset)
    wr_rise && r_ff.state == ST_IDLE |=> config_byte == $past(lvl.data) && r_ff.state != ST_IDLE)
    else $error("config not latched");
  AST_EXT_CONV: assert property (@(posedge clk) disable iff (reset)
    r_ff.state == ST_TRACK_EXT && wr_rise |=> r_ff.state == ST_CONVERT && !track_hold)
    else $error("external acquisition did not end");
  AST_CS_HIGH: assert property (@(posedge clk) disable iff (reset)
    lvl.cs_n |=> !data_oe)
    else $error("bus driven while deselected");
  AST_DONE_CLR: assert property (@(posedge clk) disable iff (reset)
    rd_fall && !conv_finish |=> conv_done_n)
    else $error("read fall did not clear done");
  AST_HOLD: assert property (@(posedge clk) disable iff (reset)
    r_ff.state == ST_TRACK_INT && cedge && r_ff.edges == HOLD_COUNT - 4'h1 |=> !track_hold ##0
    r_ff.state == ST_CONVERT)
    else $error("hold not on fourth edge");
  AST_TRACK: assert property (@(posedge clk) disable iff (reset)
    wr_rise && (r_ff.state == ST_IDLE || r_ff.state == ST_CONVERT) |=> track_hold)
    else $error("tracking not started");
  AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (reset)
    !conv_finish |=> $stable(r_ff.result))
    else $error("result changed without completion");

  // read path: the bus is driven only inside a selected strobe
  AST_OE_HOLD: assert property (@(posedge clk) disable iff (reset)
    data_oe && !lvl.cs_n && !lvl.rd_n |=> data_oe)
    else $error("bus dropped during a read");
  AST_RD_STOP: assert property (@(posedge clk) disable iff (reset)
    lvl.rd_n |=> !data_oe)
    else $error("bus driven after read strobe rose");

  // completion flag: only a qualified read raises it, completion wins a tie
  AST_DONE_KEEP: assert property (@(posedge clk) disable iff (reset)
    !conv_done_n && !rd_fall |=> !conv_done_n)
    else $error("done dropped without a read");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (reset)
    conv_finish && rd_fall |=> !conv_done_n)
    else $error("read fall beat a completion");
  AST_DONE_IDLE: assert property (@(posedge clk) disable iff (reset)
    conv_done_n && !conv_finish |=> conv_done_n)
    else $error("done asserted without completion");

  // acquisition: the mode bit picks the path, each path waits for its own event
  AST_MODE_SEL: assert property (@(posedge clk) disable iff (reset)
    wr_rise && r_ff.state == ST_IDLE |=>
    r_ff.state == ($past(lvl.data[CFG_ACQ_BIT]) ? ST_TRACK_EXT : ST_TRACK_INT))
    else $error("acquisition mode not taken from config");
  AST_CFG_KEEP: assert property (@(posedge clk) disable iff (reset)
    !wr_rise |=> $stable(config_byte))
    else $error("config changed without a write");
  AST_INT_WAIT: assert property (@(posedge clk) disable iff (reset)
    r_ff.state == ST_TRACK_INT && !cedge |=> track_hold && r_ff.state == ST_TRACK_INT)
    else $error("internal acquisition left early");
  AST_EXT_WAIT: assert property (@(posedge clk) disable iff (reset)
    r_ff.state == ST_TRACK_EXT && !wr_rise |=> track_hold && r_ff.state == ST_TRACK_EXT)
    else $error("external acquisition left early");
  AST_CONV_STAY: assert property (@(posedge clk) disable iff (reset)
    r_ff.state == ST_CONVERT && !cedge && !wr_rise |=> r_ff.state == ST_CONVERT && $stable(r_ff.result))
    else $error("conversion ended without a clock edge");
endmodule : adcphp_port
`default_nettype wire

// file: rtl/adcphp_pkg.sv
`default_nettype none
package adcphp_pkg;

  // configuration byte fields
  localparam int CFG_ACQ_BIT = 5; // low selects internal acquisition
  localparam int CFG_CLK_BIT = 6; // high selects the external converter clock
  localparam logic [7:0] CFG_RESET = 8'h00;

  // converter clock edges per phase, and system clocks per internal converter clock
  localparam logic [3:0] HOLD_EDGES = 4'h4;
  localparam logic [3:0] CONV_EDGES = 4'hC;
  localparam logic [3:0] INT_CLK_DIV = 4'h2;

  localparam int RESULT_W = 12;
  localparam int LOW_W = 8; // result bits carried by the low byte
  localparam logic [RESULT_W-1:0] RESULT_RESET = 12'h000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] HIGH_PAD = 4'h0;

  // pins of the host port, as seen after synchronising
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic high_byte_select;
    logic conv_clk;
    logic [7:0] data;
  } adcphp_pins_type;

  // idle pins: strobes and select inactive high
  localparam adcphp_pins_type PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                            high_byte_select: 1'b0, conv_clk: 1'b0, data: 8'h00};

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_TRACK_INT = 4'h2,
    ST_TRACK_EXT = 4'h4,
    ST_CONVERT = 4'h8
  } adcphp_state_type;

endpackage : adcphp_pkg
`default_nettype wire

// file: rtl/adcphp_sync.sv
`default_nettype none
module adcphp_sync #(
  parameter int W = 13,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } adcphp_sync_state_type;

  adcphp_sync_state_type r_ff, nxt_r;

  // s1 feeds only s2; edges look at s2 against s3
  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = din;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      r_ff <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign level = r_ff.s2;
  assign rise = r_ff.s2 & ~r_ff.s3;
  assign fall = ~r_ff.s2 & r_ff.s3;
endmodule : adcphp_sync
`default_nettype wire

// file: testbench/adcphp_host.sv
`default_nettype none
module adcphp_host (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output adcphp_pkg::adcphp_pins_type pins,
  output wire logic [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import adcphp_pkg::*;
  logic drv = 1'b0;
  // released bus shows the inverse of the last byte, never a stale copy
  assign data_in = data_oe ? data_out : drv ? pins.data : ~pins.data;
  // clock pin rests low; it toggles only inside cclk bursts
  initial pins = PINS_IDLE;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // external converter clock, three system clocks per phase, low between bursts
  task automatic cclk(input int n);
    tick(1);
    repeat (n) begin
      pins.conv_clk <= 1'b1;
      tick(3);
      pins.conv_clk <= 1'b0;
      tick(3);
    end
  endtask : cclk
  // configuration write, select held around the strobe
  task automatic wr(input logic [7:0] cfg);
    @(posedge clk);
    pins.cs_n <= 1'b0;
    pins.data <= cfg;
    drv <= 1'b1;
    tick(1);
    pins.wr_n <= 1'b0;
    tick(3);
    pins.wr_n <= 1'b1;
    tick(3);
    pins.cs_n <= 1'b1;
    drv <= 1'b0;
  endtask : wr
  // one byte read; sel low models a strobe with the chip deselected
  task automatic rd(input logic sel, input logic hb, output logic [7:0] d, output logic oe);
    @(posedge clk);
    pins.cs_n <= ~sel;
    pins.high_byte_select <= hb;
    tick(1);
    pins.rd_n <= 1'b0;
    tick(5);
    #1;
    d = data_out;
    oe = data_oe;
    tick(1);
    pins.rd_n <= 1'b1;
    pins.cs_n <= 1'b1;
    tick(4);
  endtask : rd
endmodule : adcphp_host
`default_nettype wire

// file: testbench/adc_parallel_host_port_tb_top.sv
`default_nettype none
module adc_parallel_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import adcphp_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [RESULT_W-1:0] sar = 12'hA5C;
  adcphp_pins_type pins;
  logic [7:0] din, dout, cfg, d;
  logic oe, done_n, th, o;
  int n_fail = 0;
  int cmp_count = 0;
  adcphp_host host_u (.clk(clk), .data_out(dout), .data_oe(oe), .pins(pins), .data_in(din));
  adcphp_port dut_u (.clk(clk), .reset(reset), .cs_n(pins.cs_n), .rd_n(pins.rd_n), .wr_n(pins.wr_n),
    .high_byte_select(pins.high_byte_select), .conv_clk_pin(pins.conv_clk), .data_in(din),
    .sar_code(sar), .data_out(dout), .data_oe(oe), .conv_done_n(done_n), .track_hold(th),
    .config_byte(cfg));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // bounded wait; the check after it catches a hang
  task automatic wait_th(input logic v);
    for (int i = 0; i < 60 && th !== v; i++) @(posedge clk);
    #1;
  endtask : wait_th
  task automatic wait_done();
    for (int i = 0; i < 200 && done_n !== 1'b0; i++) @(posedge clk);
    #1;
  endtask : wait_done
  task automatic t_reset();
    chk(oe, 1'b0);
    chk(done_n, 1'b1);
    chk(cfg, CFG_RESET);
  endtask : t_reset
  // internal acquisition, both bytes, result held across a new core code
  task automatic t_internal();
    host_u.wr(8'h8F);
    #1;
    chk(cfg, 8'h8F);
    chk(th, 1'b1);
    wait_th(1'b0);
    chk(th, 1'b0);
    wait_done();
    chk(done_n, 1'b0);
    host_u.rd(1'b1, 1'b1, d, o);
    chk(d, {HIGH_PAD, 4'hA});
    chk(o, 1'b1);
    chk(done_n, 1'b1);
    chk(oe, 1'b0);
    sar <= 12'h000;
    host_u.rd(1'b1, 1'b0, d, o);
    chk(d, 8'h5C);
  endtask : t_internal
  // external converter clock: nothing moves until the host clocks the pin
  task automatic t_ext_clock();
    host_u.wr(8'h4F);
    host_u.tick(20);
    sar <= 12'h7E2;
    #1;
    chk(cfg, 8'h4F);
    chk(th, 1'b1);
    host_u.cclk(3);
    #1;
    chk(th, 1'b1);
    host_u.cclk(1);
    #1;
    chk(th, 1'b0);
    host_u.cclk(11);
    #1;
    chk(done_n, 1'b1);
    host_u.cclk(1);
    #1;
    chk(done_n, 1'b0);
  endtask : t_ext_clock
  // strobe without select must leave the bus released and the flag set
  task automatic t_cs_high();
    host_u.rd(1'b0, 1'b0, d, o);
    chk(o, 1'b0);
    chk(done_n, 1'b0);
    host_u.rd(1'b1, 1'b1, d, o);
    chk(d, {HIGH_PAD, 4'h7});
    chk(o, 1'b1);
    chk(done_n, 1'b1);
  endtask : t_cs_high
  // external acquisition: tracking lasts until the second write
  task automatic t_external();
    host_u.wr(8'hA0);
    host_u.tick(30);
    sar <= 12'h3C1;
    #1;
    chk(th, 1'b1);
    host_u.wr(8'hA0);
    #1;
    chk(th, 1'b0);
    wait_done();
    chk(done_n, 1'b0);
    host_u.rd(1'b1, 1'b0, d, o);
    chk(d, 8'hC1);
  endtask : t_external
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_internal();
    t_external();
    t_ext_clock();
    t_cs_high();
    conclude();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    conclude();
  end
endmodule : adc_parallel_host_port_tb_top
`default_nettype wire
